//--- include/peb_pkg.sv
// Package for the parallel EEPROM host controller
package peb_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   localparam int unsigned ADDR_W = 9;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned PAGE_LSB = 4;
   localparam int unsigned POLL_BIT = 7;
   // Times in microseconds as documented
   localparam int unsigned PROGRAM_TIME_MAX_US = 10000;
   localparam int unsigned POWERUP_READ_DELAY_US = 1000;
   localparam int unsigned POWERUP_WRITE_DELAY_US = 5000;
   localparam int unsigned BYTE_LOAD_WINDOW_US = 20;
   localparam int unsigned CYC_PER_US = CLK_HZ / 1000000;
   localparam int unsigned PROGRAM_TIME_MAX_CYC = PROGRAM_TIME_MAX_US * CYC_PER_US;
   localparam int unsigned POWERUP_READ_DELAY_CYC = POWERUP_READ_DELAY_US * CYC_PER_US;
   localparam int unsigned POWERUP_WRITE_DELAY_CYC = POWERUP_WRITE_DELAY_US * CYC_PER_US;
   // Strobe low phase: 100 ns minimum pulse width, rounded up
   localparam int unsigned STROBE_NS = 100;
   // Scaled via cycles per microsecond so the product stays inside 32 bits
   localparam int unsigned STROBE_CYC = (STROBE_NS * CYC_PER_US + 999) / 1000;
   localparam int unsigned CNT_W = 24;
   localparam logic [3:0] STROBE_CYC_C = 4'(STROBE_CYC);

   typedef struct packed {
      logic chip_sel_n;
      logic out_drive_n;
      logic write_strobe_n;
   } peb_strobe_s;

   typedef enum logic [2:0] {
      PEB_PWRUP = 3'b000,
      PEB_IDLE = 3'b001,
      PEB_WSTROBE = 3'b011,
      PEB_RSTROBE = 3'b010,
      PEB_POLL = 3'b110,
      PEB_WAITPRG = 3'b111
   } peb_state_e;
endpackage

//--- logic/peb_host.sv
// Host controller driving a byte-wide EEPROM port
// Overview of operation
// - Wait 10 ms after write unless polling
// - Wait 1 ms after power-up before reads
// - Wait 5 ms after power-up before writes
// - Output-drive pulses between page loads allowed
// - Each page byte uses single-write sequencing
// - Completion polls are ordinary read cycles
// - Keep page address bits fixed per page
`timescale 1ns/10ps
`default_nettype none
module peb_host
   import peb_pkg::*;
#(
   parameter int unsigned PGM_CYC = PROGRAM_TIME_MAX_CYC, // Write cycle limit
   parameter int unsigned PUR_CYC = POWERUP_READ_DELAY_CYC, // Power-up to read
   parameter int unsigned PUW_CYC = POWERUP_WRITE_DELAY_CYC, // Power-up to write
   parameter bit USE_POLL = 1'b1 // Poll bit 7 instead of full wait
) (
   input wire logic core_clk, // 40 MHz clock
   input wire logic rst, // Sync reset, high
   input wire logic req_valid, // Request present
   output logic req_ready, // Request taken this cycle
   input wire logic req_write, // 1 write, 0 read
   input wire logic req_last, // Last byte of page
   input wire logic [ADDR_W-1:0] req_addr, // Byte address
   input wire logic [DATA_W-1:0] req_wdata, // Write data
   output logic rd_valid, // Read data pulse
   output logic [DATA_W-1:0] rd_data, // Read data
   output logic busy, // Not idle
   output logic [ADDR_W-1:0] address_lines, // Address pins
   output peb_strobe_s strobes, // Active-low strobes
   input wire logic [DATA_W-1:0] data_in, // Data pins in
   output logic [DATA_W-1:0] data_out, // Data pins out
   output logic data_oe_n // Low while host drives data
);
   peb_state_e state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt, up, next_up;
   logic [3:0] ph, next_ph;
   logic [ADDR_W-1:0] next_addr, last_addr, next_last_addr;
   logic [DATA_W-1:0] wdat, next_wdat, next_rd_data;
   logic last_bit, next_last_bit, is_last, next_is_last, next_rd_valid;
   logic page_open, next_page_open;
   peb_strobe_s next_strobes;
   logic next_oe_n;
   logic rd_ok, wr_ok;

   // Power-up counter saturates at the longer write delay
   assign rd_ok = up >= CNT_W'(PUR_CYC);
   assign wr_ok = up >= CNT_W'(PUW_CYC);
   assign busy = state != PEB_IDLE;
   // page writes are refused across a page change
   assign req_ready = state == PEB_IDLE && req_valid && (req_write ? (wr_ok &&
      (!page_open || req_addr[ADDR_W-1:PAGE_LSB] == last_addr[ADDR_W-1:PAGE_LSB])) : rd_ok);

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_up = wr_ok ? up : up + 1'b1;
      next_ph = ph;
      next_addr = address_lines;
      next_last_addr = last_addr;
      next_wdat = wdat;
      next_rd_data = rd_data;
      next_rd_valid = 1'b0;
      next_last_bit = last_bit;
      next_is_last = is_last;
      next_page_open = page_open;
      next_strobes = strobes;
      next_oe_n = data_oe_n;
      unique case (state)
         PEB_PWRUP: begin
            if (rd_ok) begin
               next_state = PEB_IDLE;
            end
         end
         PEB_IDLE: begin
            // Data pins released one cycle after a write strobe rises
            next_oe_n = 1'b1;
            if (req_ready) begin
               next_addr = req_addr;
               next_ph = '0;
               if (req_write) begin
                  // address and data settle a cycle before the strobes fall
                  next_wdat = req_wdata;
                  next_last_addr = req_addr;
                  next_last_bit = req_wdata[POLL_BIT];
                  next_is_last = req_last;
                  next_page_open = !req_last;
                  next_oe_n = 1'b0;
                  next_state = PEB_WSTROBE;
               end else begin
                  next_strobes = '{chip_sel_n: 1'b0, out_drive_n: 1'b0, write_strobe_n: 1'b1};
                  next_cnt = cnt + 1'b1;
                  next_state = PEB_RSTROBE;
               end
            end else if (page_open && cnt >= CNT_W'(BYTE_LOAD_WINDOW_US * CYC_PER_US / 2)) begin
               // close page well inside the 20 us window
               next_page_open = 1'b0;
               next_cnt = '0;
               next_ph = '0;
               next_addr = last_addr;
               next_state = USE_POLL ? PEB_POLL : PEB_WAITPRG;
            end else begin
               next_cnt = cnt + 1'b1;
            end
         end
         PEB_WSTROBE: begin
            next_ph = ph + 1'b1;
            if (ph == 4'h0) begin
               // strobes fall once the address has had a cycle of setup
               next_strobes = '{chip_sel_n: 1'b0, out_drive_n: 1'b1, write_strobe_n: 1'b0};
            end
            if (ph == STROBE_CYC_C) begin
               // data latched by the write strobe rise, still driven at that edge
               next_strobes = '{chip_sel_n: 1'b1, out_drive_n: 1'b1, write_strobe_n: 1'b1};
               next_cnt = '0;
               next_ph = '0;
               next_state = is_last ? (USE_POLL ? PEB_POLL : PEB_WAITPRG) : PEB_IDLE;
            end
         end
         PEB_RSTROBE: begin
            next_ph = ph + 1'b1;
            next_oe_n = 1'b1;
            // reads between loads still age the open page
            next_cnt = cnt + 1'b1;
            if (ph == STROBE_CYC_C) begin
               next_rd_data = data_in;
               next_rd_valid = 1'b1;
               next_strobes = '{chip_sel_n: 1'b1, out_drive_n: 1'b1, write_strobe_n: 1'b1};
               next_state = PEB_IDLE;
            end
         end
         PEB_POLL: begin
            // ordinary read cycles on the last address
            next_oe_n = 1'b1;
            next_cnt = cnt + 1'b1;
            next_ph = ph + 1'b1;
            next_strobes = '{chip_sel_n: 1'b0, out_drive_n: 1'b0, write_strobe_n: 1'b1};
            if (ph == STROBE_CYC_C) begin
               next_strobes = '{chip_sel_n: 1'b1, out_drive_n: 1'b1, write_strobe_n: 1'b1};
               next_ph = '0;
               if (data_in[POLL_BIT] == last_bit || cnt >= CNT_W'(PGM_CYC)) begin
                  next_state = PEB_IDLE;
                  next_cnt = '0;
               end
            end
         end
         PEB_WAITPRG: begin
            next_oe_n = 1'b1;
            next_cnt = cnt + 1'b1;
            if (cnt >= CNT_W'(PGM_CYC)) begin
               next_state = PEB_IDLE;
               next_cnt = '0;
            end
         end
         default: begin
            next_state = PEB_PWRUP;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state <= PEB_PWRUP;
         cnt <= '0;
         up <= '0;
         ph <= '0;
         address_lines <= '0;
         last_addr <= '0;
         wdat <= '0;
         rd_data <= '0;
         rd_valid <= 1'b0;
         last_bit <= 1'b0;
         is_last <= 1'b0;
         page_open <= 1'b0;
         strobes <= '{chip_sel_n: 1'b1, out_drive_n: 1'b1, write_strobe_n: 1'b1};
         data_oe_n <= 1'b1;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         up <= next_up;
         ph <= next_ph;
         address_lines <= next_addr;
         last_addr <= next_last_addr;
         wdat <= next_wdat;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
         last_bit <= next_last_bit;
         is_last <= next_is_last;
         page_open <= next_page_open;
         strobes <= next_strobes;
         data_oe_n <= next_oe_n;
      end
   end

   assign data_out = wdat;

   property p_no_early_write;
      @(posedge core_clk) disable iff (rst) !strobes.write_strobe_n |-> wr_ok;
   endproperty
   a_no_early_write: assert property (p_no_early_write)
      else $error("write strobe before power-up write delay");
   property p_no_early_read;
      @(posedge core_clk) disable iff (rst) !strobes.out_drive_n |-> rd_ok;
   endproperty
   a_no_early_read: assert property (p_no_early_read)
      else $error("read before power-up read delay");
   property p_no_write_read;
      @(posedge core_clk) disable iff (rst) !(!strobes.write_strobe_n && !strobes.out_drive_n);
   endproperty
   a_no_write_read: assert property (p_no_write_read)
      else $error("write and output drive low together");
   property p_drive_on_write;
      @(posedge core_clk) disable iff (rst) !strobes.write_strobe_n |-> !data_oe_n && !strobes.chip_sel_n;
   endproperty
   a_drive_on_write: assert property (p_drive_on_write)
      else $error("write strobe without chip select or data drive");
   property p_no_contention;
      @(posedge core_clk) disable iff (rst) !strobes.out_drive_n |-> data_oe_n;
   endproperty
   a_no_contention: assert property (p_no_contention)
      else $error("host drives data during read");
   property p_addr_stable;
      @(posedge core_clk) disable iff (rst)
         !strobes.write_strobe_n && !$past(strobes.write_strobe_n) |-> $stable(address_lines);
   endproperty
   a_addr_stable: assert property (p_addr_stable)
      else $error("address moved during write strobe");
   property p_data_hold;
      @(posedge core_clk) disable iff (rst) $rose(strobes.write_strobe_n) |-> !data_oe_n && $stable(data_out);
   endproperty
   a_data_hold: assert property (p_data_hold)
      else $error("data not held at write strobe rise");
   property p_poll_addr;
      @(posedge core_clk) disable iff (rst) state == PEB_POLL |-> address_lines == last_addr;
   endproperty
   a_poll_addr: assert property (p_poll_addr)
      else $error("poll not on last written address");
   property p_no_write_prog;
      @(posedge core_clk) disable iff (rst)
         (state == PEB_POLL || state == PEB_WAITPRG) |-> strobes.write_strobe_n;
   endproperty
   a_no_write_prog: assert property (p_no_write_prog)
      else $error("write strobe during programming");
   property p_wait_full;
      @(posedge core_clk) disable iff (rst)
         $past(state) == PEB_WAITPRG && state != PEB_WAITPRG |-> $past(cnt) >= CNT_W'(PGM_CYC);
   endproperty
   a_wait_full: assert property (p_wait_full)
      else $error("programming wait cut short");
endmodule
`default_nettype wire

//--- bench/peb_dev_model.sv
// Behavioural byte-wide EEPROM device seen by the host controller
`timescale 1ns/10ps
`default_nettype none
module peb_dev_model
   import peb_pkg::*;
#(
   parameter int PROG_NS = 3000, // Self-timed programming, short for sim
   parameter int WIN_NS = 20000 // Byte load window
) (
   input wire logic [ADDR_W-1:0] address_lines, // Address pins
   input wire peb_strobe_s strobes, // Active-low strobes
   input wire logic [DATA_W-1:0] data_out, // Host write data
   input wire logic data_oe_n, // Low while host drives data
   output logic [DATA_W-1:0] data_in // Device read data
);
   logic [DATA_W-1:0] mem [512];
   logic [DATA_W-1:0] pend [16];
   logic [15:0] pv;
   logic [ADDR_W-1:0] wa, last_a;
   logic prog, wr_on, rd_on;
   int id;
   assign wr_on = !strobes.chip_sel_n && strobes.out_drive_n && !strobes.write_strobe_n;
   assign rd_on = !strobes.chip_sel_n && !strobes.out_drive_n && strobes.write_strobe_n;
   initial begin
      foreach (mem[i]) mem[i] = 8'hff;
      pv = '0;
      prog = 0;
      id = 0;
      last_a = '0;
      data_in = 8'h00;
   end
   always @(posedge wr_on) begin
      if (!prog) begin
         wa = address_lines;
         id++;
         fork
            automatic int my = id;
            begin
               #WIN_NS;
               if (my == id) begin
                  prog = 1;
                  #PROG_NS;
                  foreach (pend[i]) if (pv[i]) mem[{last_a[8:4], 4'(i)}] = pend[i];
                  pv = '0;
                  prog = 0;
               end
            end
         join_none
      end
   end
   always @(negedge wr_on) begin
      if (!prog) begin
         // Undriven data pins latch as garbage
         pend[wa[3:0]] = data_oe_n ? ~data_out : data_out;
         pv[wa[3:0]] = 1'b1;
         last_a = wa;
      end
   end
   // Released bus flips so a stale value never passes for data
   always @(rd_on, address_lines, prog, pv) begin
      if (rd_on) begin
         data_in = mem[address_lines];
         if ((prog || pv != 0) && address_lines == last_a) data_in[7] = !pend[last_a[3:0]][7];
      end else data_in = ~data_in;
   end
endmodule
`default_nettype wire

//--- bench/peb_host_tb_top.sv
// Self-checking bench for the EEPROM host controller
`timescale 1ns/10ps
`default_nettype none
module peb_host_tb_top
   import peb_pkg::*;
;
   logic core_clk, rst, req_valid, req_ready, req_write, req_last, rd_valid, busy, data_oe_n;
   logic [ADDR_W-1:0] req_addr, address_lines;
   logic [DATA_W-1:0] req_wdata, rd_data, data_in, data_out, lfsr;
   peb_strobe_s strobes;
   logic [DATA_W-1:0] ref_mem [512];
   logic [4:0] pgs [3] = '{5'h03, 5'h1f, 5'h00};
   int cnt [3] = '{16, 1, 5};
   int error_cnt, cmp_count, n;
   logic load_on;
   logic [ADDR_W-1:0] load_a;
   peb_host #(.PGM_CYC(2000), .PUR_CYC(20), .PUW_CYC(50), .USE_POLL(1'b1)) i_peb_host (.core_clk, .rst,
      .req_valid, .req_ready, .req_write, .req_last, .req_addr, .req_wdata, .rd_valid, .rd_data, .busy,
      .address_lines, .strobes, .data_in, .data_out, .data_oe_n);
   peb_dev_model i_peb_dev_model (.address_lines, .strobes, .data_out, .data_oe_n, .data_in);
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic bound();
      n++;
      if (n >= 5000) begin
         error_cnt++;
         $display("[FAIL] %0t wait timed out", $time);
         finish_test();
      end
   endtask
   task automatic req(input logic w, input logic l, input logic [8:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_last <= l;
      req_addr <= a;
      req_wdata <= d;
      n = 0;
      do begin
         @(negedge core_clk);
         bound();
      end while (req_ready !== 1'b1);
      @(posedge core_clk);
      req_valid <= 1'b0;
      if (w) begin
         load_on = !l;
         load_a = a;
      end else begin
         n = 0;
         do begin
            @(negedge core_clk);
            bound();
         end while (rd_valid !== 1'b1);
         // Read of the byte still loading is a poll: only bit 7 is defined
         if (load_on && a == load_a) chk({7'h00, rd_data[7]}, {7'h00, !ref_mem[a][7]});
         else chk(rd_data, ref_mem[a]);
      end
   endtask
   initial begin
      core_clk = 0;
      forever #12.5 core_clk = ~core_clk;
   end
   initial begin
      rst = 1;
      req_valid = 0;
      req_write = 0;
      req_last = 0;
      req_addr = '0;
      req_wdata = '0;
      error_cnt = 0;
      cmp_count = 0;
      load_on = 0;
      load_a = '0;
      lfsr = 8'h57;
      foreach (ref_mem[i]) ref_mem[i] = 8'hff;
      repeat (8) @(posedge core_clk);
      rst <= 0;
      req_valid <= 1'b1;
      @(negedge core_clk);
      chk({5'h00, strobes}, 8'h07);
      chk({7'h00, req_ready}, 8'h00);
      chk({7'h00, busy}, 8'h01);
      for (int t = 0; t < 3; t++) begin
         for (int k = 0; k < cnt[t]; k++) begin
            lfsr = lfsr_next(lfsr);
            ref_mem[{pgs[t], 4'(k)}] = lfsr;
            req(1'b1, (t != 1) && (k == cnt[t] - 1), {pgs[t], 4'(k)}, lfsr);
         end
         // Last byte read first so the poll result is seen
         for (int k = 0; k < 16; k++) req(1'b0, 1'b0, {pgs[t], 4'(cnt[t] - 1 - k)}, 8'h00);
         $display("test page %0d done", t);
      end
      finish_test();
   end
endmodule
`default_nettype wire
